// ===== tmr_pkg.sv
package tmr_pkg;
    // ==========================================
    // Register index map of the I/O space
    localparam logic [5:0] ADDR_T1_BASE = 6'h00;
    localparam logic [5:0] ADDR_T3_BASE = 6'h10;
    localparam logic [5:0] ADDR_MASK = 6'h20;
    localparam logic [5:0] ADDR_MASK_EXT = 6'h21;
    localparam logic [5:0] ADDR_FLAGS = 6'h22;
    localparam logic [5:0] ADDR_FLAGS_EXT = 6'h23;
    localparam logic [5:0] ADDR_T1_CTRL = 6'h24;
    localparam logic [5:0] ADDR_T3_CTRL = 6'h25;
    // ==========================================
    // Byte-pair slots inside a timer block
    localparam logic [2:0] SLOT_COUNT = 3'h0;
    localparam logic [2:0] SLOT_CMP_A = 3'h1;
    localparam logic [2:0] SLOT_CMP_B = 3'h2;
    localparam logic [2:0] SLOT_CMP_C = 3'h3;
    localparam logic [2:0] SLOT_CAPTURE = 3'h4;
    localparam int NUM_SLOTS = 5;
    // ==========================================
    // Mask and flag bit positions
    localparam int BIT_CAPTURE = 5;
    localparam int BIT_CMP_A = 4;
    localparam int BIT_CMP_B = 3;
    localparam int BIT_OVERFLOW = 2;
    localparam int BIT_T3_CMP_C = 1;
    localparam int BIT_T1_CMP_C = 0;
    localparam logic [7:0] MASK_IMPL = 8'h3C;
    localparam logic [7:0] MASK_EXT_IMPL = 8'h3F;
    // ==========================================
    // Control register fields
    localparam int CTRL_TOP_CAP = 0;
    localparam int CTRL_EDGE_RISE = 1;
    localparam int CTRL_ACOMP_SEL = 2;
    localparam logic [7:0] CTRL_IMPL = 8'h07;
    // ==========================================
    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// ===== tmr_sync.sv
module tmr_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule

// ===== tmr_unit.sv
module tmr_unit #(
    parameter int W = 16,
    parameter int NCMP = 3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic top_cap_i,
    input wire logic cap_evt_i,
    input wire logic cnt_wr_i,
    input wire logic cap_wr_i,
    input wire logic [NCMP-1:0] cmp_wr_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] count_o,
    output logic [W-1:0] capture_o,
    output logic [NCMP*W-1:0] cmp_o,
    output logic [NCMP-1:0] match_o,
    output logic ovf_o,
    output logic cap_flag_o,
    output logic [NCMP-1:0] cmp_pin_o
);
    import tmr_pkg::*;

    logic [W-1:0] cnt_ff;
    logic [W-1:0] cap_ff;
    logic block_ff;
    logic ovf_ff;
    logic capf_ff;
    logic [NCMP-1:0] match_ff;
    logic [NCMP-1:0] pin_ff;
    logic top_hit;
    logic run_tick;

    // Capture register doubles as TOP; the pin is ignored meanwhile
    assign top_hit = top_cap_i && (cnt_ff == cap_ff);
    // A CPU write in the tick cycle owns the counter
    assign run_tick = tick_i && !cnt_wr_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= RST_WORD;
        end else if (cnt_wr_i) begin
            cnt_ff <= wdata_i;
        end else if (tick_i) begin
            cnt_ff <= top_hit ? '0 : W'(cnt_ff + 1'b1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            block_ff <= 1'b0;
        end else if (cnt_wr_i) begin
            block_ff <= 1'b1;
        end else if (tick_i) begin
            block_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_ff <= RST_WORD;
        end else if (cap_wr_i) begin
            cap_ff <= wdata_i;
        end else if (cap_evt_i && !top_cap_i) begin
            cap_ff <= cnt_ff;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capf_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else begin
            capf_ff <= (cap_evt_i && !top_cap_i) || (run_tick && top_hit);
            ovf_ff <= run_tick && !top_hit && (cnt_ff == {W{1'b1}});
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCMP; g++) begin : g_cmp
            logic [W-1:0] cmp_ff;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cmp_ff <= RST_WORD;
                    match_ff[g] <= 1'b0;
                    pin_ff[g] <= 1'b0;
                end else begin
                    if (cmp_wr_i[g]) begin
                        cmp_ff <= wdata_i;
                    end
                    match_ff[g] <= run_tick && !block_ff && (cnt_ff == cmp_ff); // RQ3 RQ5
                    if (match_ff[g]) begin
                        pin_ff[g] <= !pin_ff[g];
                    end
                end
            end
            assign cmp_o[g*W +: W] = cmp_ff;
        end
    endgenerate

    assign count_o = cnt_ff;
    assign capture_o = cap_ff;
    assign match_o = match_ff;
    assign ovf_o = ovf_ff;
    assign cap_flag_o = capf_ff;
    assign cmp_pin_o = pin_ff;
endmodule

// ===== tmr_regs.sv
// Function
// [RQ1] Counter as two bytes, atomic via holding
// [RQ2] One holding byte shared by all pairs
// [RQ3] Counter write blocks next compare match
// [RQ4] Software: changing running counter may skip matches
// [RQ5] Compares run continuously, drive flag and pin
// [RQ6] Compare bytes commit together via holding
// [RQ7] Capture loads counter on pin/comparator event
// [RQ8] Capture register may serve as TOP
// [RQ9] Capture reads return one coherent snapshot
// [RQ10] Request needs enable, flag and global bit
// [RQ11] Primary mask bits five to two
// [RQ12] Extended mask bits five to zero
// [RQ13] First timer compare C at extended bit0
// [RQ14] Software writes zero to extended top bits
// [RQ15] Extended mask unavailable in legacy mode
// [RQ16] Compare flag sets tick after equality
// [RQ17] Flags clear on vector or written one
// [RQ18] High byte first; low write commits, low read latches
// [RQ19] Second timer mirrors first timer layout
module tmr_regs (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [5:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    input wire logic gie_i,
    input wire logic compat_mode_i,
    input wire logic t1_tick_i,
    input wire logic t3_tick_i,
    input wire logic t1_capture_input_pin_i,
    input wire logic t3_capture_input_pin_i,
    input wire logic t1_acomp_i,
    input wire logic [7:0] irq_ack_i,
    input wire logic [7:0] irq_ack_ext_i,
    output logic [7:0] irq_req_o,
    output logic [7:0] irq_req_ext_o,
    output logic [2:0] t1_compare_output_pin_o,
    output logic [2:0] t3_compare_output_pin_o
);
    import tmr_pkg::*;

    // ==========================================
    // Address decoding
    function automatic logic pair_hit(input logic [5:0] a);
        pair_hit = !a[5] && (a[3:1] < 3'(NUM_SLOTS));
    endfunction

    function automatic logic [4:0] slot_strobe(input logic [5:0] a, input logic unit);
        slot_strobe = (pair_hit(a) && !a[0] && (a[4] == unit)) ? 5'(5'h01 << a[3:1]) : 5'h00;
    endfunction

    logic [7:0] temp_ff;
    logic [7:0] rdata_ff;
    logic [7:0] msk_ff;
    logic [7:0] emsk_ff;
    logic [7:0] tif_ff;
    logic [7:0] etif_ff;
    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl3_ff;
    logic [3:0] sync_s;
    logic [1:0] cap_prev_ff;
    logic compat_s;
    logic [4:0] com1;
    logic [4:0] com3;
    logic [15:0] wword;
    logic [15:0] cnt1;
    logic [15:0] cnt3;
    logic [15:0] cap1;
    logic [15:0] cap3;
    logic [47:0] cmp1;
    logic [47:0] cmp3;
    logic [2:0] match1;
    logic [2:0] match3;
    logic ovf1;
    logic ovf3;
    logic capf1;
    logic capf3;
    logic [1:0] cap_lvl;
    logic [1:0] cap_evt;
    logic [15:0] rd_word;
    logic [7:0] nxt_rdata;
    logic [7:0] nxt_tif;
    logic [7:0] nxt_etif;
    logic [7:0] tif_set;
    logic [7:0] etif_set;
    logic [7:0] emsk_eff;

    // ==========================================
    // Pin synchronisers and capture edge detection
    tmr_sync #(
        .W(4)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i({compat_mode_i, t1_acomp_i, t3_capture_input_pin_i, t1_capture_input_pin_i}),
        .sync_o(sync_s)
    );

    assign compat_s = sync_s[3];
    // Changing the source select may fake one edge; software should
    // clear the capture flag after switching
    assign cap_lvl[0] = ctrl1_ff[CTRL_ACOMP_SEL] ? sync_s[2] : sync_s[0];
    assign cap_lvl[1] = sync_s[1];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_prev_ff <= 2'h0;
        end else begin
            cap_prev_ff <= cap_lvl;
        end
    end

    assign cap_evt[0] = ctrl1_ff[CTRL_EDGE_RISE] ? (cap_lvl[0] && !cap_prev_ff[0])
                                               : (!cap_lvl[0] && cap_prev_ff[0]); // RQ7
    assign cap_evt[1] = ctrl3_ff[CTRL_EDGE_RISE] ? (cap_lvl[1] && !cap_prev_ff[1])
                                               : (!cap_lvl[1] && cap_prev_ff[1]);

    // ==========================================
    // Shared holding byte and 16-bit commits
    assign wword = {temp_ff, io_wdata_i}; // RQ2
    assign com1 = io_wr_i ? slot_strobe(io_addr_i, 1'b0) : 5'h00; // RQ1 RQ6 RQ18
    assign com3 = io_wr_i ? slot_strobe(io_addr_i, 1'b1) : 5'h00;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_ff <= RST_BYTE;
        end else if (io_wr_i && pair_hit(io_addr_i) && io_addr_i[0]) begin
            temp_ff <= io_wdata_i; // RQ18
        end else if (io_rd_i && pair_hit(io_addr_i) && !io_addr_i[0]) begin
            temp_ff <= rd_word[15:8]; // RQ9 RQ18
        end
    end

    tmr_unit #(
        .W(16),
        .NCMP(3)
    ) u_t1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(t1_tick_i),
        .top_cap_i(ctrl1_ff[CTRL_TOP_CAP]), // RQ8
        .cap_evt_i(cap_evt[0]),
        .cnt_wr_i(com1[SLOT_COUNT]),
        .cap_wr_i(com1[SLOT_CAPTURE]),
        .cmp_wr_i(com1[SLOT_CMP_C:SLOT_CMP_A]),
        .wdata_i(wword),
        .count_o(cnt1),
        .capture_o(cap1),
        .cmp_o(cmp1),
        .match_o(match1),
        .ovf_o(ovf1),
        .cap_flag_o(capf1),
        .cmp_pin_o(t1_compare_output_pin_o)
    );

    // Same layout as the first timer; capture source is the pin only, no comparator select
    tmr_unit #(
        .W(16),
        .NCMP(3)
    ) u_t3 ( // RQ19
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(t3_tick_i),
        .top_cap_i(ctrl3_ff[CTRL_TOP_CAP]),
        .cap_evt_i(cap_evt[1]),
        .cnt_wr_i(com3[SLOT_COUNT]),
        .cap_wr_i(com3[SLOT_CAPTURE]),
        .cmp_wr_i(com3[SLOT_CMP_C:SLOT_CMP_A]),
        .wdata_i(wword),
        .count_o(cnt3),
        .capture_o(cap3),
        .cmp_o(cmp3),
        .match_o(match3),
        .ovf_o(ovf3),
        .cap_flag_o(capf3),
        .cmp_pin_o(t3_compare_output_pin_o)
    );

    // ==========================================
    // Control and mask registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl1_ff <= RST_BYTE;
            ctrl3_ff <= RST_BYTE;
        end else if (io_wr_i && io_addr_i == ADDR_T1_CTRL) begin
            ctrl1_ff <= io_wdata_i & CTRL_IMPL;
        end else if (io_wr_i && io_addr_i == ADDR_T3_CTRL) begin
            ctrl3_ff <= io_wdata_i & CTRL_IMPL & ~(8'h01 << CTRL_ACOMP_SEL);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msk_ff <= RST_BYTE;
        end else if (io_wr_i && io_addr_i == ADDR_MASK) begin
            msk_ff <= io_wdata_i & MASK_IMPL; // RQ11
        end
    end

    // Top two bits are not stored, so a stray one written there is harmless
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            emsk_ff <= RST_BYTE;
        end else if (io_wr_i && io_addr_i == ADDR_MASK_EXT && !compat_s) begin
            emsk_ff <= io_wdata_i & MASK_EXT_IMPL; // RQ12 RQ13 RQ14 RQ15
        end
    end

    assign emsk_eff = compat_s ? 8'h00 : emsk_ff; // RQ15

    // ==========================================
    // Event flags: set beats clear in the same cycle
    always_comb begin
        tif_set = 8'h00;
        etif_set = 8'h00;
        tif_set[BIT_CAPTURE] = capf1;
        tif_set[BIT_CMP_A] = match1[0]; // RQ16
        tif_set[BIT_CMP_B] = match1[1];
        tif_set[BIT_OVERFLOW] = ovf1;
        etif_set[BIT_T1_CMP_C] = match1[2]; // RQ13
        etif_set[BIT_CAPTURE] = capf3;
        etif_set[BIT_CMP_A] = match3[0];
        etif_set[BIT_CMP_B] = match3[1];
        etif_set[BIT_OVERFLOW] = ovf3;
        etif_set[BIT_T3_CMP_C] = match3[2];
    end

    always_comb begin
        nxt_tif = tif_ff & ~irq_ack_i;
        nxt_etif = etif_ff & ~irq_ack_ext_i;
        if (io_wr_i && io_addr_i == ADDR_FLAGS) begin
            nxt_tif = nxt_tif & ~io_wdata_i; // RQ17
        end
        if (io_wr_i && io_addr_i == ADDR_FLAGS_EXT) begin
            nxt_etif = nxt_etif & ~io_wdata_i;
        end
        nxt_tif = (nxt_tif | tif_set) & MASK_IMPL;
        nxt_etif = (nxt_etif | etif_set) & MASK_EXT_IMPL;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tif_ff <= RST_BYTE;
            etif_ff <= RST_BYTE;
        end else begin
            tif_ff <= nxt_tif;
            etif_ff <= nxt_etif;
        end
    end

    // Requests go straight to the core's vector logic
    assign irq_req_o = (gie_i ? 8'hFF : 8'h00) & msk_ff & tif_ff; // RQ10 RQ11
    assign irq_req_ext_o = (gie_i ? 8'hFF : 8'h00) & emsk_eff & etif_ff; // RQ10 RQ12

    // ==========================================
    // Read path
    always_comb begin
        rd_word = 16'h0000;
        case ({io_addr_i[4], io_addr_i[3:1]})
            {1'b0, SLOT_COUNT}: rd_word = cnt1;
            {1'b0, SLOT_CMP_A}: rd_word = cmp1[15:0];
            {1'b0, SLOT_CMP_B}: rd_word = cmp1[31:16];
            {1'b0, SLOT_CMP_C}: rd_word = cmp1[47:32];
            {1'b0, SLOT_CAPTURE}: rd_word = cap1;
            {1'b1, SLOT_COUNT}: rd_word = cnt3;
            {1'b1, SLOT_CMP_A}: rd_word = cmp3[15:0];
            {1'b1, SLOT_CMP_B}: rd_word = cmp3[31:16];
            {1'b1, SLOT_CMP_C}: rd_word = cmp3[47:32];
            {1'b1, SLOT_CAPTURE}: rd_word = cap3;
            default: rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (pair_hit(io_addr_i)) begin
            nxt_rdata = io_addr_i[0] ? temp_ff : rd_word[7:0]; // RQ1 RQ9
        end else begin
            case (io_addr_i)
                ADDR_MASK: nxt_rdata = msk_ff;
                ADDR_MASK_EXT: nxt_rdata = emsk_eff;
                ADDR_FLAGS: nxt_rdata = tif_ff;
                ADDR_FLAGS_EXT: nxt_rdata = etif_ff;
                ADDR_T1_CTRL: nxt_rdata = ctrl1_ff;
                ADDR_T3_CTRL: nxt_rdata = ctrl3_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= RST_BYTE;
        end else if (io_rd_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign io_rdata_o = rdata_ff;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    low_read_latch_a: // RQ18
    assert property (io_rd_i && !io_wr_i && io_addr_i == ADDR_T1_BASE
                     |=> temp_ff == $past(cnt1[15:8]) && io_rdata_o == $past(cnt1[7:0]))
        else $error("low read did not latch high byte");

    count_commit_a: // RQ1
    assert property (io_wr_i && io_addr_i == ADDR_T1_BASE
                     |=> cnt1 == {$past(temp_ff), $past(io_wdata_i)})
        else $error("counter write not atomic");

    shared_temp_a: // RQ2
    assert property (io_wr_i && io_addr_i == (ADDR_T1_BASE | 6'h03) ##1 !io_wr_i && !io_rd_i
                     ##1 io_wr_i && io_addr_i == (ADDR_T3_BASE | 6'h04)
                     |=> cmp3[31:16] == {$past(io_wdata_i, 3), $past(io_wdata_i)})
        else $error("holding byte not shared");

    write_block_a: // RQ3
    assert property (io_wr_i && io_addr_i == ADDR_T1_BASE ##1 !t1_tick_i ##1 (t1_tick_i && !io_wr_i)
                     |=> match1 == 3'h0)
        else $error("match not blocked after counter write");

    cmp_match_a: // RQ5
    assert property (t1_tick_i && !com1[SLOT_COUNT] && cnt1 == cmp1[15:0] && $past(t1_tick_i, 2)
                     && !$past(com1[SLOT_COUNT]) && !$past(com1[SLOT_COUNT], 2) |=> match1[0])
        else $error("compare match missed");

    flag_after_a: // RQ16
    assert property (match1[0] |=> tif_ff[BIT_CMP_A])
        else $error("compare flag not set after match");

    capture_load_a: // RQ7
    assert property (cap_evt[0] && !ctrl1_ff[CTRL_TOP_CAP] && !com1[SLOT_CAPTURE]
                     |=> cap1 == $past(cnt1) ##1 tif_ff[BIT_CAPTURE])
        else $error("capture did not load counter");

    capture_top_a: // RQ8
    assert property (ctrl1_ff[CTRL_TOP_CAP] && t1_tick_i && !com1[SLOT_COUNT] && cnt1 == cap1
                     |=> cnt1 == 16'h0000)
        else $error("counter did not wrap at capture top");

    capture_pair_a: // RQ9
    assert property (io_rd_i && !io_wr_i && io_addr_i == (ADDR_T3_BASE | 6'h08)
                     ##1 !io_rd_i && !io_wr_i
                     ##1 io_rd_i && !io_wr_i && io_addr_i == (ADDR_T3_BASE | 6'h09)
                     |=> io_rdata_o == $past(cap3[15:8], 3))
        else $error("capture halves not coherent");

    irq_gate_a: // RQ10
    assert property ((irq_req_o != 8'h00 || irq_req_ext_o != 8'h00) |-> gie_i)
        else $error("request without global enable");

    t1c_pos_a: // RQ13
    assert property (irq_req_ext_o[BIT_T1_CMP_C] |-> etif_ff[BIT_T1_CMP_C] && emsk_ff[BIT_T1_CMP_C])
        else $error("compare C request misplaced");

    legacy_hide_a: // RQ15
    assert property (compat_s |-> irq_req_ext_o == 8'h00 ##1 $stable(emsk_ff) || !$past(compat_s))
        else $error("extended mask active in legacy mode");

    flag_clear_a: // RQ17
    assert property (irq_ack_i[BIT_OVERFLOW] && !ovf1 |=> !tif_ff[BIT_OVERFLOW])
        else $error("overflow flag not cleared by vector");
endmodule

// ===== tmr_cpu.sv
module tmr_cpu
    import tmr_pkg::*;
(
    input wire logic clk_i,
    output logic [5:0] io_addr_o,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [7:0] io_wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Core bus cycles, launched on the falling edge
    initial begin
        io_addr_o = 6'h3F;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
    end
    // Idle bus shows inverted leftovers so nothing leans on stale values
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_i);
        io_addr_o = a;
        io_wdata_o = (a == ADDR_MASK_EXT) ? (d & 8'h3F) : d;
        io_wr_o = 1'b1;
        @(negedge clk_i);
        io_wr_o = 1'b0;
        io_wdata_o = ~io_wdata_o;
        io_addr_o = ~io_addr_o;
    endtask
    task automatic rd(input logic [5:0] a);
        @(negedge clk_i);
        io_addr_o = a;
        io_rd_o = 1'b1;
        @(negedge clk_i);
        io_rd_o = 1'b0;
        io_addr_o = ~io_addr_o;
    endtask
    // High byte goes first so the low write commits the pair
    task automatic wr16(input logic [5:0] a, input logic [15:0] v);
        wr(a | 6'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask
endmodule

// ===== tb_tmr_regs.sv
module tb_tmr_regs;
    import tmr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic gie = 1'b0;
    logic compat = 1'b0;
    logic t1_tick = 1'b0;
    logic t1_cap = 1'b0;
    logic t3_cap = 1'b0;
    logic t3_tick = 1'b0;
    logic t1_acomp = 1'b0;
    logic [7:0] irq_ack = 8'h00;
    logic [7:0] irq_ack_ext = 8'h00;
    logic [7:0] irq_req;
    logic [7:0] irq_req_ext;
    logic [2:0] pin1;
    logic [2:0] pin3;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [15:0] v;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 82;
    always #2.5 clk_i = ~clk_i;
    tmr_cpu i_tmr_cpu (.clk_i(clk_i), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata));
    tmr_regs i_tmr_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
        .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .gie_i(gie), .compat_mode_i(compat), .t1_tick_i(t1_tick),
        .t3_tick_i(t3_tick), .t1_capture_input_pin_i(t1_cap), .t3_capture_input_pin_i(t3_cap), .t1_acomp_i(t1_acomp),
        .irq_ack_i(irq_ack), .irq_ack_ext_i(irq_ack_ext), .irq_req_o(irq_req), .irq_req_ext_o(irq_req_ext),
        .t1_compare_output_pin_o(pin1), .t3_compare_output_pin_o(pin3));
    // ==========================================
    // Checking
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        if (exp_q.size() != 0) bad_count++;
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Read data lands on the edge that takes the strobe
    always @(posedge clk_i) rd_seen <= io_rd;
    always @(negedge clk_i) begin
        if (rd_seen === 1'b1) check(io_rdata, exp_q.pop_front());
    end
    // ==========================================
    // Stimulus helpers
    task automatic rd8(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_tmr_cpu.rd(a);
    endtask
    task automatic rd16(input logic [5:0] a, input logic [15:0] e);
        rd8(a, e[7:0]);
        rd8(a | 6'h01, e[15:8]);
    endtask
    task automatic tick(input int n, input logic u = 1'b0);
        repeat (n) begin
            @(negedge clk_i);
            if (u) t3_tick = 1'b1;
            else t1_tick = 1'b1;
            @(negedge clk_i);
            t1_tick = 1'b0;
            t3_tick = 1'b0;
        end
    endtask
    // Lands on the cycle where the compare A flag must appear
    task automatic hit_a();
        i_tmr_cpu.wr16(ADDR_T1_BASE, 16'h0004);
        tick(2);
        @(negedge clk_i);
    endtask
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        for (int t = 0; t < 2; t++) begin
            for (int s = 0; s < NUM_SLOTS; s++) rd16(6'(16 * t + 2 * s), RST_WORD);
        end
        rd8(ADDR_MASK, RST_BYTE);
        rd8(ADDR_MASK_EXT, RST_BYTE);
        for (int t = 0; t < 2; t++) begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
                v = 16'($random(seed));
                i_tmr_cpu.wr16(6'(16 * t + 2 * s), v);
                rd16(6'(16 * t + 2 * s), v);
            end
        end
        // One holding byte serves every pair, for writes and reads alike
        i_tmr_cpu.wr(6'h03, 8'hA5);
        i_tmr_cpu.wr(6'h14, 8'h5A);
        rd16(6'h14, 16'hA55A);
        rd8(6'h14, 8'h5A);
        rd8(6'h07, 8'hA5);
        i_tmr_cpu.wr(ADDR_MASK, 8'hFF);
        rd8(ADDR_MASK, MASK_IMPL);
        i_tmr_cpu.wr(ADDR_MASK_EXT, 8'hFF);
        rd8(ADDR_MASK_EXT, MASK_EXT_IMPL);
        compat = 1'b1;
        repeat (3) @(negedge clk_i);
        rd8(ADDR_MASK_EXT, 8'h00);
        i_tmr_cpu.wr(ADDR_MASK_EXT, 8'h00);
        compat = 1'b0;
        repeat (3) @(negedge clk_i);
        rd8(ADDR_MASK_EXT, MASK_EXT_IMPL);
        rd8(6'h3F, 8'h00);
        gie = 1'b1;
        i_tmr_cpu.wr16(6'h02, 16'h0005);
        i_tmr_cpu.wr16(ADDR_T1_BASE, 16'h0005);
        tick(1);
        repeat (2) @(negedge clk_i);
        rd8(ADDR_FLAGS, 8'h00);
        check({5'h00, pin1}, 8'h00);
        hit_a();
        check(irq_req, 8'h10);
        check({5'h00, pin1}, 8'h01);
        gie = 1'b0;
        @(negedge clk_i);
        check(irq_req, 8'h00);
        gie = 1'b1;
        irq_ack = 8'h10;
        @(negedge clk_i);
        irq_ack = 8'h00;
        @(negedge clk_i);
        check(irq_req, 8'h00);
        hit_a();
        check(irq_req, 8'h10);
        i_tmr_cpu.wr(ADDR_FLAGS, 8'h10);
        rd8(ADDR_FLAGS, 8'h00);
        i_tmr_cpu.wr16(ADDR_T1_BASE, 16'hFFFF);
        tick(1);
        @(negedge clk_i);
        check(irq_req, 8'h04);
        i_tmr_cpu.wr(ADDR_FLAGS, 8'h04);
        for (int t = 0; t < 2; t++) begin
            i_tmr_cpu.wr(ADDR_T1_CTRL + 6'(t), 8'h02);
            v = 16'($random(seed));
            i_tmr_cpu.wr16(6'(16 * t), v);
            if (t == 0) t1_cap = 1'b1;
            else t3_cap = 1'b1;
            repeat (6) @(negedge clk_i);
            rd16(6'(16 * t + 8), v);
            rd8(ADDR_FLAGS + 6'(t), 8'h20);
        end
        check(irq_req_ext, 8'h20);
        compat = 1'b1;
        repeat (3) @(negedge clk_i);
        check(irq_req_ext, 8'h00);
        compat = 1'b0;
        repeat (3) @(negedge clk_i);
        check(irq_req_ext, 8'h20);
        irq_ack_ext = 8'h20;
        @(negedge clk_i);
        irq_ack_ext = 8'h00;
        @(negedge clk_i);
        check(irq_req_ext, 8'h00);
        i_tmr_cpu.wr16(6'h12, 16'h0007);
        i_tmr_cpu.wr16(ADDR_T3_BASE, 16'h0006);
        tick(2, 1'b1);
        @(negedge clk_i);
        check(irq_req_ext, 8'h10);
        check({5'h00, pin3}, 8'h01);
        // Comparator as capture source; the pin stays high and must not count
        i_tmr_cpu.wr(ADDR_FLAGS, 8'h20);
        i_tmr_cpu.wr(ADDR_T1_CTRL, 8'h06);
        t1_acomp = 1'b1;
        repeat (6) @(negedge clk_i);
        rd8(ADDR_FLAGS, 8'h20);
        // Capture as TOP: count 0,1,2 then wraps, capture flag follows
        i_tmr_cpu.wr(ADDR_FLAGS, 8'h20);
        i_tmr_cpu.wr16(6'h08, 16'h0002);
        i_tmr_cpu.wr(ADDR_T1_CTRL, 8'h01);
        i_tmr_cpu.wr16(ADDR_T1_BASE, 16'h0000);
        tick(3);
        repeat (2) @(negedge clk_i);
        rd16(ADDR_T1_BASE, 16'h0000);
        rd8(ADDR_FLAGS, 8'h20);
        i_tmr_cpu.wr16(6'h06, 16'h0001);
        i_tmr_cpu.wr16(ADDR_T1_BASE, 16'h0000);
        tick(2);
        @(negedge clk_i);
        check(irq_req_ext, 8'h11);
        check({5'h00, pin1}, 8'h04);
        repeat (3) @(negedge clk_i);
        finish_test();
    end
endmodule
